/* File: design/rpis_flag.sv */
// one sticky interrupt flag, set wins over clear
`timescale 1ns/1ps
module rpis_flag (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic setEvt,
    input wire logic clearEvt,
    output logic flag
);
    logic next_flag;

    // an event in the clearing cycle must not be lost
    assign next_flag = setEvt | (flag & ~clearEvt);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (clk_en) begin
            flag <= next_flag;
        end
    end
endmodule

/* File: design/rpis_pkg.sv */
// shared constants and types for the receive port interrupt status block
package rpis_pkg;

    // byte address width of the register slave
    localparam int ADDR_W = 10;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ICR_HI = 8'hd8;
    localparam logic [7:0] IDX_ICR_LO = 8'hd9;
    localparam logic [7:0] IDX_ISR_HI = 8'hda;
    localparam logic [7:0] IDX_ISR_LO = 8'hdb;
    localparam logic [7:0] IDX_STS_FIRST = 8'h4d;
    localparam logic [7:0] IDX_STS_SECOND = 8'h4e;

    localparam logic [7:0] RST_BYTE = 8'h00;
    // implemented bits; everything else reads as zero
    localparam logic [7:0] HI_USED = 8'h07;
    localparam logic [7:0] LO_USED = 8'h77;

    // high status byte fields
    localparam int HI_ENC = 2;
    localparam int HI_SEQ = 1;
    localparam int HI_CRC = 0;
    // low status byte fields
    localparam int LO_LEN = 6;
    localparam int LO_CNT = 5;
    localparam int LO_OVF = 4;
    localparam int LO_PAR = 2;
    localparam int LO_VALID = 1;
    localparam int LO_LOCK = 0;

    // first port status layout
    localparam int S1_LOCK = 0;
    localparam int S1_VALID = 1;
    localparam int S1_LOCK_CHG = 2;
    localparam int S1_PAR = 3;
    localparam int S1_CRC = 4;
    localparam int S1_SEQ = 5;
    // second port status layout
    localparam int S2_LEN = 0;
    localparam int S2_CNT = 1;
    localparam int S2_OVF = 2;
    localparam int S2_ENC = 3;

    // single-cycle event pulses from the receive port, core_clk domain
    typedef struct packed {
        logic encodeError;
        logic ctrlSeqError;
        logic ctrlChecksumError;
        logic lineLengthChange;
        logic lineCountChange;
        logic rxOverflow;
        logic linkParityError;
    } rpis_evt_t;

endpackage

/* File: design/rpis_sync.sv */
// two-stage level synchroniser for asynchronous inputs
`timescale 1ns/1ps
module rpis_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    initial begin
        if (WIDTH < 1) begin
            $error("rpis_sync: WIDTH must be at least 1");
        end
    end

    // stage1 feeds only the second flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout <= '0;
        end else if (clk_en) begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

/* File: design/rpis_top.sv */
// receive port interrupt status registers with avalon-mm slave
// Operation
// RULE_01: encode error sets high bit 2, second-read clears
// RULE_02: control seq error sets high bit 1
// RULE_03: control checksum error sets high bit 0
// RULE_04: line length change sets low bit 6
// RULE_05: line count change sets low bit 5
// RULE_06: receive buffer overflow sets low bit 4
// RULE_07: link parity error sets low bit 2
// RULE_08: port valid change sets low bit 1
// RULE_09: lock change sets low bit 0
// RULE_10: high status read-only, reset zero, 7:3 zero
// RULE_11: low status read-only, reset zero, 7,3 zero
// RULE_12: interrupt only where matching enable bit set
// RULE_13: irq is OR of enabled flags; flags sticky
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module rpis_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [rpis_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire rpis_pkg::rpis_evt_t portEvents,
    input wire logic lockLevelPin,
    input wire logic portValidPin,
    output logic portIrq
);
    // enable bytes
    logic [7:0] enableHigh;
    logic [7:0] enableLow;
    // flag vector: high byte in 15:8, low byte in 7:0
    logic [15:0] flags;
    logic [15:0] setVec;
    logic [15:0] clrVec;
    // constant on purpose: it steers which flag flops get built
    localparam logic [15:0] USED_MASK = {rpis_pkg::HI_USED, rpis_pkg::LO_USED};
    logic [1:0] syncLevels;
    logic [1:0] prevLevels;
    logic lockChanged;
    logic portValidChanged;

    // bus decode
    wire [7:0] regIdx = address[rpis_pkg::ADDR_W-1:2];
    wire reqPending = read | write;
    wire accept = reqPending & ~waitrequest;
    wire wrLane0 = accept & write & byteenable[0];
    wire wrEnableHigh = wrLane0 & (regIdx == rpis_pkg::IDX_ICR_HI);
    wire wrEnableLow = wrLane0 & (regIdx == rpis_pkg::IDX_ICR_LO);
    wire rdFirst = accept & read & (regIdx == rpis_pkg::IDX_STS_FIRST);
    wire rdSecond = accept & read & (regIdx == rpis_pkg::IDX_STS_SECOND);

    wire [7:0] statusHigh = flags[15:8];
    wire [7:0] statusLow = flags[7:0];

    // port status views: live levels and pending conditions
    wire [7:0] statusFirst = {2'b00,
                              statusHigh[rpis_pkg::HI_SEQ],
                              statusHigh[rpis_pkg::HI_CRC],
                              statusLow[rpis_pkg::LO_PAR],
                              statusLow[rpis_pkg::LO_LOCK],
                              syncLevels[1],
                              syncLevels[0]};
    wire [7:0] statusSecond = {4'h0,
                               statusHigh[rpis_pkg::HI_ENC],
                               statusLow[rpis_pkg::LO_OVF],
                               statusLow[rpis_pkg::LO_CNT],
                               statusLow[rpis_pkg::LO_LEN]};

    // read mux; unmapped addresses read zero
    wire selEnHi = (regIdx == rpis_pkg::IDX_ICR_HI);
    wire selEnLo = (regIdx == rpis_pkg::IDX_ICR_LO);
    wire selIsHi = (regIdx == rpis_pkg::IDX_ISR_HI);
    wire selIsLo = (regIdx == rpis_pkg::IDX_ISR_LO);
    wire selSt1 = (regIdx == rpis_pkg::IDX_STS_FIRST);
    wire selSt2 = (regIdx == rpis_pkg::IDX_STS_SECOND);
    wire [7:0] readByte = ({8{selEnHi}} & enableHigh)
                        | ({8{selEnLo}} & enableLow)
                        | ({8{selIsHi}} & statusHigh & rpis_pkg::HI_USED) // RULE_10
                        | ({8{selIsLo}} & statusLow & rpis_pkg::LO_USED) // RULE_11
                        | ({8{selSt1}} & statusFirst)
                        | ({8{selSt2}} & statusSecond);

    // one wait state per access keeps readdata a plain flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else if (clk_en) begin
            if (reqPending && waitrequest) begin
                waitrequest <= 1'b0;
                readdata <= {24'h000000, readByte};
            end else begin
                waitrequest <= 1'b1;
            end
        end
    end

    // enable registers; reserved bits never stored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enableHigh <= rpis_pkg::RST_BYTE;
            enableLow <= rpis_pkg::RST_BYTE;
        end else if (clk_en) begin
            if (wrEnableHigh) begin
                enableHigh <= writedata[7:0] & rpis_pkg::HI_USED;
            end
            if (wrEnableLow) begin
                enableLow <= writedata[7:0] & rpis_pkg::LO_USED;
            end
        end
    end

    // levels from the link side are asynchronous
    rpis_sync #(
        .WIDTH(2)
    ) u_level_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .din({portValidPin, lockLevelPin}),
        .dout(syncLevels)
    );

    // a pin already high at reset release counts as one change
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prevLevels <= 2'b00;
        end else if (clk_en) begin
            prevLevels <= syncLevels;
        end
    end

    assign lockChanged = syncLevels[0] ^ prevLevels[0]; // RULE_09
    assign portValidChanged = syncLevels[1] ^ prevLevels[1]; // RULE_08

    // set sources
    always_comb begin
        setVec = 16'h0000;
        setVec[8 + rpis_pkg::HI_ENC] = portEvents.encodeError; // RULE_01
        setVec[8 + rpis_pkg::HI_SEQ] = portEvents.ctrlSeqError; // RULE_02
        setVec[8 + rpis_pkg::HI_CRC] = portEvents.ctrlChecksumError; // RULE_03
        setVec[rpis_pkg::LO_LEN] = portEvents.lineLengthChange; // RULE_04
        setVec[rpis_pkg::LO_CNT] = portEvents.lineCountChange; // RULE_05
        setVec[rpis_pkg::LO_OVF] = portEvents.rxOverflow; // RULE_06
        setVec[rpis_pkg::LO_PAR] = portEvents.linkParityError; // RULE_07
        setVec[rpis_pkg::LO_VALID] = portValidChanged; // RULE_08
        setVec[rpis_pkg::LO_LOCK] = lockChanged; // RULE_09
    end

    // clearing reads of the port status registers
    always_comb begin
        clrVec = 16'h0000;
        clrVec[8 + rpis_pkg::HI_ENC] = rdSecond; // RULE_01
        clrVec[8 + rpis_pkg::HI_SEQ] = rdFirst; // RULE_02
        clrVec[8 + rpis_pkg::HI_CRC] = rdFirst; // RULE_03
        clrVec[rpis_pkg::LO_LEN] = rdSecond; // RULE_04
        clrVec[rpis_pkg::LO_CNT] = rdSecond; // RULE_05
        clrVec[rpis_pkg::LO_OVF] = rdSecond; // RULE_06
        clrVec[rpis_pkg::LO_PAR] = rdFirst; // RULE_07
        clrVec[rpis_pkg::LO_VALID] = rdFirst; // RULE_08
        clrVec[rpis_pkg::LO_LOCK] = rdFirst; // RULE_09
    end

    // reserved positions get no flop at all
    for (genvar i = 0; i < 16; i++) begin : g_flag
        if (USED_MASK[i]) begin : g_used
            rpis_flag u_flag (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .setEvt(setVec[i]),
                .clearEvt(clrVec[i]),
                .flag(flags[i])
            ); // RULE_13
        end else begin : g_resv
            assign flags[i] = 1'b0; // RULE_10
        end
    end

    // interrupt output registered, one cycle behind the flags
    wire irqAny = |(flags & {enableHigh, enableLow}); // RULE_12

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            portIrq <= 1'b0;
        end else if (clk_en) begin
            portIrq <= irqAny; // RULE_13
        end
    end
endmodule

/* File: test/rpis_top_asserts.sv */
// concurrent checks on the receive port interrupt status block
`timescale 1ns/1ps
module rpis_top_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [rpis_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire rpis_pkg::rpis_evt_t portEvents,
    input wire logic portIrq
);
    rpis_pkg::rpis_evt_t evQ;
    wire logic [7:0] idx = address[9:2];
    // events seen at the previous live edge; frozen edges count as none
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) evQ <= '0;
        else evQ <= clk_en ? portEvents : '0;
    end
    property setRd(ev, idx0, b);
        @(posedge core_clk) disable iff (!rst_n)
        ev && clk_en && read && waitrequest && idx == idx0 |=> readdata[b];
    endproperty
    property rdZero(idx0, mask);
        @(posedge core_clk) disable iff (!rst_n)
        read && !waitrequest && idx == idx0 |-> (readdata & mask) == 32'h0;
    endproperty
    enc_sets_a: assert property (setRd(evQ.encodeError, rpis_pkg::IDX_ISR_HI, 2))
        else $error("encode flag missing");
    seq_sets_a: assert property (setRd(evQ.ctrlSeqError, rpis_pkg::IDX_ISR_HI, 1))
        else $error("sequence flag missing");
    crc_sets_a: assert property (setRd(evQ.ctrlChecksumError, rpis_pkg::IDX_ISR_HI, 0))
        else $error("checksum flag missing");
    len_sets_a: assert property (setRd(evQ.lineLengthChange, rpis_pkg::IDX_ISR_LO, 6))
        else $error("length flag missing");
    cnt_sets_a: assert property (setRd(evQ.lineCountChange, rpis_pkg::IDX_ISR_LO, 5))
        else $error("count flag missing");
    ovf_sets_a: assert property (setRd(evQ.rxOverflow, rpis_pkg::IDX_ISR_LO, 4))
        else $error("overflow flag missing");
    par_sets_a: assert property (setRd(evQ.linkParityError, rpis_pkg::IDX_ISR_LO, 2))
        else $error("parity flag missing");
    hi_zero_a: assert property (rdZero(rpis_pkg::IDX_ISR_HI, 32'hffff_fff8))
        else $error("high status reserved bits set");
    lo_zero_a: assert property (rdZero(rpis_pkg::IDX_ISR_LO, 32'hffff_ff88))
        else $error("low status reserved bits set");
    cover property (@(posedge core_clk) $rose(portIrq));
    cover property (@(posedge core_clk) read && !waitrequest);
    cover property (@(posedge core_clk) write && !waitrequest);
endmodule
bind rpis_top rpis_top_asserts i_chk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .portEvents(portEvents), .portIrq(portIrq));

/* File: test/tb.sv */
// self-checking bench for the receive port interrupt status block
`timescale 1ns/1ps
module tb;
    logic core_clk, rst_n, clk_en, read, write, lockLevelPin, portValidPin, portIrq, waitrequest;
    logic [9:0] address;
    logic [31:0] writedata, readdata, rv, r;
    logic [3:0] byteenable;
    logic [7:0] mHi, mLo, eHi, eLo;
    rpis_pkg::rpis_evt_t portEvents;
    int num_errors, checks, seed, i;
    rpis_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .portEvents(portEvents),
        .lockLevelPin(lockLevelPin), .portValidPin(portValidPin), .portIrq(portIrq));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is seen low, then idles one edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, wd};
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            results();
        end
        rv = readdata;
        read <= 0;
        write <= 0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(0, idx, 8'h00);
        chk(rv, {24'h0, exp});
    endtask
    task automatic clr(input logic sec);
        logic [7:0] exp1;
        // port status shows the flags as they stood before the clear
        exp1 = sec ? {4'h0, mHi[2], mLo[4], mLo[5], mLo[6]}
                   : {2'b00, mHi[1:0], mLo[2], mLo[0], portValidPin, lockLevelPin};
        bus(0, sec ? rpis_pkg::IDX_STS_SECOND : rpis_pkg::IDX_STS_FIRST, 8'h00);
        chk(rv, {24'h0, exp1});
        mHi &= sec ? 8'hfb : 8'hfc;
        mLo &= sec ? 8'h8f : 8'hf8;
    endtask
    // one-cycle event; a frozen clock must not record it
    task automatic pulse(input logic [6:0] e);
        portEvents <= e;
        @(posedge core_clk);
        portEvents <= '0;
        if (clk_en) begin
            mHi |= {5'h0, e[6:4]};
            mLo |= {1'b0, e[3:1], 1'b0, e[0], 2'b00};
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        results();
    end
    initial begin
        seed = 43;
        {rst_n, read, write, lockLevelPin, portValidPin, mHi, mLo} = '0;
        {address, writedata, portEvents, num_errors, checks} = '0;
        clk_en = 1;
        byteenable = 4'hf;
        repeat (12) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        bus(1, rpis_pkg::IDX_ISR_HI, 8'hff);
        bus(1, rpis_pkg::IDX_ISR_LO, 8'hff);
        rd(rpis_pkg::IDX_ISR_HI, 8'h00);
        rd(rpis_pkg::IDX_ISR_LO, 8'h00);
        rd(8'h10, 8'h00);
        chk(portIrq, 0);
        // a write without lane 0 must leave the enable byte alone
        byteenable <= 4'he;
        bus(1, rpis_pkg::IDX_ICR_HI, 8'hff);
        byteenable <= 4'hf;
        rd(rpis_pkg::IDX_ICR_HI, 8'h00);
        $display("test reset done");
        bus(1, rpis_pkg::IDX_ICR_HI, 8'hff);
        bus(1, rpis_pkg::IDX_ICR_LO, 8'hff);
        rd(rpis_pkg::IDX_ICR_LO, rpis_pkg::LO_USED);
        for (i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
            rd(i > 3 ? rpis_pkg::IDX_ISR_HI : rpis_pkg::IDX_ISR_LO, i > 3 ? mHi : mLo);
            chk(portIrq, 1);
            clr(i == 6 || (i > 0 && i < 4));
            rd(rpis_pkg::IDX_ISR_HI, mHi);
            rd(rpis_pkg::IDX_ISR_LO, mLo);
            chk(portIrq, 0);
        end
        for (i = 0; i < 4; i++) begin
            if (i % 2) portValidPin <= !portValidPin;
            else lockLevelPin <= !lockLevelPin;
            repeat (6) @(posedge core_clk);
            mLo[i%2] = 1'b1;
            rd(rpis_pkg::IDX_ISR_LO, mLo);
            clr(0);
            rd(rpis_pkg::IDX_ISR_LO, mLo);
        end
        // event held through the clearing edge must survive it
        fork
            clr(0);
            begin
                portEvents <= 7'h01;
                repeat (2) @(posedge core_clk);
                portEvents <= '0;
            end
        join
        mLo[rpis_pkg::LO_PAR] = 1'b1;
        rd(rpis_pkg::IDX_ISR_LO, mLo);
        chk(portIrq, 1);
        $display("test events done");
        // random masks, events and clears against the model
        for (i = 0; i < 60; i++) begin
            r = $random(seed);
            bus(1, rpis_pkg::IDX_ICR_HI, r[7:0]);
            bus(1, rpis_pkg::IDX_ICR_LO, r[15:8]);
            eHi = r[7:0] & rpis_pkg::HI_USED;
            eLo = r[15:8] & rpis_pkg::LO_USED;
            clk_en <= r[16] | r[17];
            pulse(r[24:18]);
            clk_en <= 1;
            rd(rpis_pkg::IDX_ICR_HI, eHi);
            chk(portIrq, |((mHi & eHi) | (mLo & eLo)));
            if (r[25]) clr(r[26]);
            rd(r[27] ? rpis_pkg::IDX_ISR_HI : rpis_pkg::IDX_ISR_LO, r[27] ? mHi : mLo);
        end
        $display("test random done");
        results();
    end
endmodule
